/* File: core/sec_client.sv */
// Purpose: two-wire bus client front end of a serial eeprom
// Assumes: host drives the clock; pins are asynchronous to clk_in
// Notes:   array and page buffer sit outside this block; the address counter is kept here
// Summary of operation
// - host picks transfer direction; device follows
// - respond only when chip-select pins match address
// - data line only pulled low or released
// - data changes only while clock low
// - write-protect high blocks writes, reads unaffected
// - data change during clock high is start/stop
// - hold output 300 ns after clock falls
// - programming cycle ends within 5 ms
// - control byte: code 1010, selects, direction
// - start falls, stop rises, clock high
// - protected write acked, no cycle, ready immediately
`timescale 1ns/1ps
`include "sec_map.svh"
module sec_client #(
  parameter int unsigned WC_CYCLES = `SEC_WC_CYC
) (
  input  wire logic      clk_in,
  input  wire logic      rst_in,
  input  wire logic      scl_clk_in,
  input  wire logic      sda_in,
  output logic           sda_out,
  output logic           sda_oe_out,
  input  wire logic      wp_in,
  input  wire logic      chip_select_bit0_in,
  input  wire logic      chip_select_bit1_in,
  input  wire logic      chip_select_bit2_in,
  input  wire logic [7:0] rd_data_in,
  output logic           rd_req_out,
  output sec_pkg::sec_wr_t wr_out,
  output logic           commit_out,
  output logic           busy_out
);
  import sec_pkg::*;

  localparam logic [5:0]  HOLD_CYC = 6'(`SEC_HOLD_CYC);
  localparam logic [19:0] WC_LAST  = 20'(WC_CYCLES - 1);

  logic                   link_bit;
  logic                   link_tog;
  logic [`SEC_SYNC_W-1:0] raw;
  logic [`SEC_SYNC_W-1:0] sync1, sync2, sync3, filt;
  logic [`SEC_SYNC_W-1:0] next_filt;
  logic                   prev_scl, prev_sda, tog_seen;
  logic                   scl_f, sda_f, wp_f, tog_f;
  logic [2:0]             cs_f;
  logic                   start_ev, stop_ev, rise_ev, fall_ev;
  sec_state_t             state, next_state;
  logic [3:0]             bit_cnt, next_bit_cnt;
  logic [7:0]             shreg, next_shreg, tx, next_tx;
  logic [14:0]            addr, next_addr;
  logic                   dirty, next_dirty;
  logic                   pend, next_pend, drive, next_drive;
  logic [5:0]             hold, next_hold;
  sec_wr_t                wr, next_wr;
  logic                   rd_req, next_rd_req, commit, next_commit;
  logic                   busy, next_busy;
  logic [19:0]            busy_cnt, next_busy_cnt;

  // link-clock side: sample a bit on each rising serial clock
  sec_link_sampler u_link (
    .scl_clk_in (scl_clk_in),
    .sda_in     (sda_in),
    .bit_out    (link_bit),
    .tog_out    (link_tog)
  );

  // pins and the link toggle enter through three flops
  assign raw = {link_tog, chip_select_bit2_in, chip_select_bit1_in,
                chip_select_bit0_in, wp_in, sda_in, scl_clk_in};

  // a filtered bit follows once second and third stage agree
  genvar gi;
  generate
    for (gi = 0; gi < `SEC_SYNC_W; gi++) begin : g_filt
      assign next_filt[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : filt[gi];
    end
  endgenerate

  // synchroniser registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt  <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= next_filt;
    end
  end

  assign scl_f = filt[`SEC_SCL];
  assign sda_f = filt[`SEC_SDA];
  assign wp_f  = filt[`SEC_WP];
  assign cs_f  = filt[`SEC_CS_LSB +: 3];
  assign tog_f = filt[`SEC_TOG];

  // bus conditions: data edges with clock high are start or stop
  assign start_ev = prev_scl & scl_f & prev_sda & ~sda_f;
  assign stop_ev  = prev_scl & scl_f & ~prev_sda & sda_f;
  assign rise_ev  = tog_f != tog_seen;
  assign fall_ev  = prev_scl & ~scl_f;

  // bus state machine and bit handling
  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_tx       = tx;
    next_addr     = addr;
    next_dirty    = dirty;
    next_pend     = pend;
    next_drive    = drive;
    next_hold     = hold;
    next_wr       = wr;
    next_wr.valid = 1'b0;
    next_rd_req   = 1'b0;
    next_commit   = 1'b0;
    if (start_ev || stop_ev) begin
      next_state   = stop_ev ? SEC_IDLE : SEC_CTRL;
      next_bit_cnt = 4'h0;
      next_pend    = 1'b0;
      next_drive   = 1'b0;
      next_hold    = 6'h00;
      next_dirty   = 1'b0;
      next_commit  = stop_ev & dirty;
    end else if (state != SEC_IDLE && state != SEC_SKIP) begin
      if (rise_ev) begin
        if (bit_cnt < 4'h8) begin
          next_shreg   = {shreg[6:0], link_bit};
          next_bit_cnt = bit_cnt + 4'h1;
        end else begin
          next_bit_cnt = 4'h9;
          if (state == SEC_READ && link_bit) begin
            next_state = SEC_SKIP;
          end
        end
      end else if (fall_ev) begin
        next_hold = HOLD_CYC;
        if (bit_cnt == 4'h8) begin
          next_pend = 1'b1;
          case (state)
            SEC_CTRL: begin
              if (shreg[7:4] == `SEC_CTRL_CODE && shreg[3:1] == cs_f
                  && !busy) begin
                next_state = shreg[0] ? SEC_READ : SEC_ADDR_HI;
              end else begin
                next_pend  = 1'b0;
                next_state = SEC_SKIP;
              end
            end
            SEC_ADDR_HI: begin
              next_addr[14:8] = shreg[6:0];
              next_state      = SEC_ADDR_LO;
            end
            SEC_ADDR_LO: begin
              next_addr[7:0] = shreg;
              next_state     = SEC_WDATA;
            end
            SEC_WDATA: begin
              if (!wp_f) begin
                next_wr    = '{valid: 1'b1, addr: addr, data: shreg};
                next_dirty = 1'b1;
                next_addr  = addr + 15'h0001;
              end
            end
            default: begin
              next_pend = 1'b0;                               // host acks a read byte
            end
          endcase
        end else if (bit_cnt == 4'h9) begin
          next_bit_cnt = 4'h0;
          next_pend    = 1'b0;
          if (state == SEC_READ) begin
            next_tx     = rd_data_in;
            next_rd_req = 1'b1;
            next_pend   = ~rd_data_in[7];
          end
        end else if (state == SEC_READ) begin
          next_pend = ~tx[3'(4'h7 - bit_cnt)];
        end
      end else if (hold != 6'h00) begin
        next_hold = hold - 6'h01;
        if (hold == 6'h01) begin
          next_drive = pend;
        end
      end
    end
  end

  // bus state registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state    <= SEC_IDLE;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      tx       <= 8'h00;
      addr     <= 15'h0000;
      dirty    <= 1'b0;
      pend     <= 1'b0;
      drive    <= 1'b0;
      hold     <= 6'h00;
      wr       <= '0;
      rd_req   <= 1'b0;
      commit   <= 1'b0;
      prev_scl <= 1'b0;
      prev_sda <= 1'b0;
      tog_seen <= 1'b0;
    end else begin
      state    <= next_state;
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      tx       <= next_tx;
      addr     <= next_addr;
      dirty    <= next_dirty;
      pend     <= next_pend;
      drive    <= next_drive;
      hold     <= next_hold;
      wr       <= next_wr;
      rd_req   <= next_rd_req;
      commit   <= next_commit;
      prev_scl <= scl_f;
      prev_sda <= sda_f;
      tog_seen <= tog_f;
    end
  end

  // self-timed programming cycle
  always_comb begin
    next_busy     = busy;
    next_busy_cnt = busy_cnt;
    if (commit) begin
      next_busy     = 1'b1;
      next_busy_cnt = WC_LAST;
    end else if (busy) begin
      if (busy_cnt == 20'h00000) begin
        next_busy = 1'b0;
      end else begin
        next_busy_cnt = busy_cnt - 20'h00001;
      end
    end
  end

  // programming cycle registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy     <= 1'b0;
      busy_cnt <= 20'h00000;
    end else begin
      busy     <= next_busy;
      busy_cnt <= next_busy_cnt;
    end
  end

  // open-drain pin: only low or released
  assign sda_out    = 1'b0;
  assign sda_oe_out = drive;
  assign rd_req_out = rd_req;
  assign wr_out     = wr;
  assign commit_out = commit;
  assign busy_out   = busy;

  // checking aids: cycles since the last clock fall, run length of busy
  logic [7:0]  since_fall;
  logic [20:0] busy_run;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      since_fall <= 8'h00;
      busy_run   <= 21'h000000;
    end else begin
      since_fall <= fall_ev ? 8'h00 : (since_fall == 8'hFF ? 8'hFF : since_fall + 8'h01);
      busy_run   <= busy ? busy_run + 21'h000001 : 21'h000000;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  only_pull_low_a: assert property (sda_oe_out |-> sda_out == 1'b0)
    else $error("data line driven high");
  low_clock_change_a: assert property ($changed(drive) && !$past(start_ev) && !$past(stop_ev)
    |-> !scl_f)
    else $error("data output changed while clock high");
  output_hold_a: assert property ($changed(drive) && !$past(start_ev) && !$past(stop_ev)
    |-> since_fall >= 8'(`SEC_HOLD_CYC))
    else $error("data output changed too soon after clock fall");
  select_match_a: assert property (state == SEC_CTRL && next_state != SEC_CTRL
    && next_state != SEC_SKIP && !start_ev && !stop_ev
    |-> shreg[3:1] == cs_f && shreg[7:4] == `SEC_CTRL_CODE)
    else $error("acknowledged a control byte that does not address this device");
  protect_block_a: assert property (wr.valid |-> !$past(wp_f))
    else $error("write byte passed while write-protect high");
  protect_no_cycle_a: assert property (commit |-> $past(dirty)
    && !$past(busy))
    else $error("programming cycle without an unprotected write");
  cycle_bound_a: assert property (busy_run <= 21'(WC_CYCLES))
    else $error("programming cycle longer than its limit");
  cycle_hold_a: assert property ($rose(busy) |-> busy[*8])
    else $error("programming cycle ended too early");
  start_resets_a: assert property (start_ev |=> state == SEC_CTRL && bit_cnt == 4'h0
    && !drive)
    else $error("start condition did not restart the receiver");
  stop_idles_a: assert property (stop_ev |=> state == SEC_IDLE ##1 state == SEC_IDLE
    || start_ev)
    else $error("stop condition did not return to idle");

  write_seen_c: cover property (commit ##1 busy);
  read_seen_c:  cover property (rd_req ##[1:300] state == SEC_SKIP);
  protect_seen_c: cover property (state == SEC_WDATA && fall_ev && bit_cnt == 4'h8 && wp_f);
  reject_seen_c: cover property (state == SEC_CTRL ##1 state == SEC_SKIP);
endmodule

/* File: core/sec_map.svh */
// Purpose: offsets, field positions and timing counts of the serial eeprom client
// Assumes: system clock of 125 MHz
// Notes:   definitions only
`ifndef SEC_MAP_SVH
`define SEC_MAP_SVH

// system clock period and derived counts
`define SEC_CLK_NS     8
`define SEC_HOLD_NS    300
`define SEC_HOLD_CYC   ((`SEC_HOLD_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS)
`define SEC_WC_MS      5
`define SEC_WC_CYC     (`SEC_WC_MS * 1000000 / `SEC_CLK_NS)

// control byte device-type code
`define SEC_CTRL_CODE  4'hA

// positions in the synchronised pin vector
`define SEC_SYNC_W     7
`define SEC_SCL        0
`define SEC_SDA        1
`define SEC_WP         2
`define SEC_CS_LSB     3
`define SEC_TOG        6

`endif

/* File: core/sec_pkg.sv */
// Purpose: types shared by the serial eeprom client
// Assumes: nothing
// Notes:   constants live in sec_map.svh
package sec_pkg;

  // bus state machine
  typedef enum logic [2:0] {
    SEC_IDLE    = 3'b000,
    SEC_CTRL    = 3'b001,
    SEC_ADDR_HI = 3'b010,
    SEC_ADDR_LO = 3'b011,
    SEC_WDATA   = 3'b100,
    SEC_READ    = 3'b101,
    SEC_SKIP    = 3'b110
  } sec_state_t;

  // one received write byte
  typedef struct packed {
    logic        valid;
    logic [14:0] addr;
    logic [7:0]  data;
  } sec_wr_t;

endpackage

/* File: core/sec_link_sampler.sv */
// Purpose: samples the data line on each rising serial clock edge
// Assumes: serial clock only runs while a host clocks a frame
// Notes:   toggle marks each new bit; bit stays stable until the next edge
`timescale 1ns/1ps
module sec_link_sampler (
  input  wire logic scl_clk_in,
  input  wire logic sda_in,
  output logic      bit_out,
  output logic      tog_out
);
  // power-up values, no reset reaches this domain
  logic bit_q = 1'b0;
  logic tog_q = 1'b0;
  logic next_bit_q;
  logic next_tog_q;

  // capture the bit and flip the event toggle
  always_comb begin
    next_bit_q = sda_in;
    next_tog_q = ~tog_q;
  end

  // register on the link clock
  always_ff @(posedge scl_clk_in) begin
    bit_q <= next_bit_q;
    tog_q <= next_tog_q;
  end

  assign bit_out = bit_q;
  assign tog_out = tog_q;
endmodule

/* File: verif/sec_host_model.sv */
// Purpose: behavioural two-wire bus host that makes the serial clock
// Assumes: line released means pulled high outside this model
// Notes:   every task starts with the clock low, except from idle, and ends with it low, except stop
`timescale 1ns/1ps
module sec_host_model #(
  parameter int HALF_NS = 500
) (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // idle bus: both lines high, clock stands still between frames
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  // one clock pulse; data set mid-low, sampled mid-high
  task automatic bit_cycle(input logic b, output logic s);
    #(HALF_NS/2) sda_low_out = ~b;
    #(HALF_NS/2) scl_out = 1'b1;
    #(HALF_NS/2) s = sda_in;
    #(HALF_NS/2) scl_out = 0;
  endtask

  // start or repeated start: release, raise clock, then pull data low
  task automatic start();
    #(HALF_NS/2) sda_low_out = 1'b0;
    #(HALF_NS/2) scl_out = 1'b1;
    #(HALF_NS) sda_low_out = 1'b1;
    #(HALF_NS) scl_out = 1'b0;
  endtask

  // stop: data low, clock high, then data released
  task automatic stop();
    #(HALF_NS/2) sda_low_out = 1'b1;
    #(HALF_NS/2) scl_out = 1'b1;
    #(HALF_NS) sda_low_out = 1'b0;
    #(HALF_NS);
  endtask

  // byte out msb first, then the acknowledge slot released
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, ack);
  endtask

  // byte in msb first, then host acknowledge or not
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, d[i]);
    end
    bit_cycle(nack, s);
  endtask
endmodule

/* File: verif/sec_client_bench.sv */
// Purpose: self-checking bench of the serial eeprom client
// Assumes: host model clocks the serial link at 1 us per bit
// Notes:   write cycle shortened to WC clock cycles
`timescale 1ns/1ps
module sec_client_bench;
  import sec_pkg::*;
  localparam int WC = 2000;
  logic        clk_in, rst_in, wp, cs0, cs1, cs2, sda_oe, sda_o, scl, host_low, sda;
  logic [7:0]  rd_data, d;
  logic        rd_req, commit, busy, ack, acc;
  sec_wr_t     wr;
  int          bad_count, n_compared, n_commit, n_rd, busy_cnt;
  logic [23:0] wq[$];
  realtime     t_fall;

  // system clock, 8 ns
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // open-drain wire with pull-up
  assign sda = ~(host_low | (sda_oe & ~sda_o));

  sec_client #(.WC_CYCLES(WC)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .scl_clk_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .wp_in(wp),
    .chip_select_bit0_in(cs0), .chip_select_bit1_in(cs1), .chip_select_bit2_in(cs2),
    .rd_data_in(rd_data), .rd_req_out(rd_req), .wr_out(wr),
    .commit_out(commit), .busy_out(busy));

  sec_host_model #(.HALF_NS(500)) host (.sda_in(sda), .scl_out(scl), .sda_low_out(host_low));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // collect pulses and count busy cycles
  always @(posedge clk_in) begin
    if (wr.valid === 1'b1) wq.push_back({1'b0, wr.addr, wr.data});
    if (commit === 1'b1) n_commit++;
    if (rd_req === 1'b1) n_rd++;
    if (busy === 1'b1) busy_cnt++;
  end

  // drive changes only late in the clock-low phase
  always @(negedge scl) t_fall = $realtime;
  always @(sda_oe) begin
    if (rst_in === 1'b0 && $realtime > 0) begin
      check("oe_clk_low", 32'(scl), 32'h0);
      check("oe_hold", 32'(($realtime - t_fall) >= 300.0), 32'h1);
      check("sda_level", 32'(sda_o), 32'h0);
    end
  end

  task automatic clr();
    wq.delete();
    n_commit = 0;
    n_rd     = 0;
    busy_cnt = 0;
    acc      = 1'b0;
  endtask

  task automatic send(input logic [7:0] b);
    host.wbyte(b, ack);
    acc = acc | ack;
  endtask

  task automatic probe(input logic [7:0] c);
    host.start();
    host.wbyte(c, ack);
    host.stop();
  endtask

  // only the strapped select and code 1010 answer; stray clocks ignored
  task automatic t_select();
    clr();
    for (int k = 0; k < 8; k++) begin
      probe({4'hA, 3'(k), 1'b0});
      check("sel_ack", 32'(ack), (k == 5) ? 32'h0 : 32'h1);
    end
    probe(8'h6A);
    check("code_ack", 32'(ack), 32'h1);
    host.wbyte(8'hAA, ack);
    host.stop();
    check("stray_ack", 32'(ack), 32'h1);
    check("sel_quiet", 32'(wq.size() + n_commit + busy_cnt), 32'h0);
    $display("test select done");
  endtask

  // two-byte write across the low-byte boundary, then busy refusal
  task automatic t_write();
    clr();
    host.start();
    send(8'hAA);
    send(8'h81);
    send(8'hFF);
    send(8'h5A);
    send(8'hC3);
    host.stop();
    check("wr_acks", 32'(acc), 32'h0);
    repeat (20) @(posedge clk_in);
    #1 probe(8'hAA);
    check("busy_nack", 32'(ack), 32'h1);
    repeat (WC + 100) @(posedge clk_in);
    check("wr_count", 32'(wq.size()), 32'h2);
    check("wr_first", 32'(wq[0]), 32'h01FF5A);
    check("wr_second", 32'(wq[1]), 32'h0200C3);
    check("commit", 32'(n_commit), 32'h1);
    check("busy_len", 32'(busy_cnt), 32'(WC));
    $display("test write done");
  endtask

  // protected write is acked, changes nothing, next command served at once
  task automatic t_protect();
    clr();
    @(posedge clk_in);
    #1 wp = 1'b1;
    host.start();
    send(8'hAA);
    send(8'h00);
    send(8'h10);
    send(8'h77);
    host.stop();
    check("wp_acks", 32'(acc), 32'h0);
    probe(8'hAA);
    check("wp_ready", 32'(ack), 32'h0);
    repeat (50) @(posedge clk_in);
    check("wp_quiet", 32'(wq.size() + n_commit + busy_cnt), 32'h0);
    @(posedge clk_in);
    #1 wp = 1'b0;
    $display("test protect done");
  endtask

  // repeated start turns a write into a two-byte read
  task automatic t_read();
    clr();
    @(posedge clk_in);
    #1 rd_data = 8'h3C;
    host.start();
    send(8'hAA);
    send(8'h00);
    host.start();
    send(8'hAB);
    host.rbyte(1'b0, d);
    @(posedge clk_in);
    #1 rd_data = 8'hC5;
    check("rd_first", 32'(d), 32'h3C);
    host.rbyte(1'b1, d);
    host.stop();
    check("rd_second", 32'(d), 32'hC5);
    check("rd_acks", 32'(acc), 32'h0);
    check("rd_reqs", 32'(n_rd), 32'h2);
    check("rd_quiet", 32'(wq.size() + n_commit), 32'h0);
    $display("test read done");
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, well beyond the expected 300 us, under 100k clocks
  initial begin
    #600000;
    bad_count++;
    final_report();
  end

  // straps settle before any bus activity
  initial begin
    rst_in  = 1'b1;
    wp      = 1'b0;
    {cs2, cs1, cs0} = 3'h5;
    rd_data = 8'h00;
    repeat (20) @(posedge clk_in);
    #1 rst_in = 1'b0;
    repeat (20) @(posedge clk_in);
    #1 t_select();
    t_write();
    t_protect();
    t_read();
    final_report();
  end
endmodule
